// ==== core/bdpc_pkg.sv ====
// constants and types for the bridge decay and protection controller
package bdpc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 50;
    localparam int OFF_TIME_NS        = 25000;
    localparam int DEAD_TIME_NS       = 400;
    localparam int STANDBY_TIME_US    = 1000;
    localparam int RETRY_TIME_US      = 2000;
    localparam int OFF_CYCLES         = OFF_TIME_NS / CLK_PERIOD_NS;
    localparam int FAST_CYCLES        = OFF_CYCLES / 2;
    localparam int DEAD_CYCLES        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STANDBY_CYCLES     = (STANDBY_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int RETRY_CYCLES       = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W              = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BDPC_DRIVE,
        BDPC_FAST,
        BDPC_DEAD,
        BDPC_SLOW
    } bdpc_phase_e;

    // gate order: {high_a, low_a, high_b, low_b}
    localparam logic [3:0] GATES_OFF   = 4'h0;
    localparam logic [3:0] GATES_FWD   = 4'h9;
    localparam logic [3:0] GATES_REV   = 4'h6;
    localparam logic [3:0] GATES_BRAKE = 4'h5;
endpackage

// ==== core/bdpc_core.sv ====
// bridge decay and protection control logic
`timescale 1ns/10ps
`default_nettype none
module bdpc_core #(
    parameter int STANDBY_LIMIT = bdpc_pkg::STANDBY_CYCLES,
    parameter int RETRY_LIMIT   = bdpc_pkg::RETRY_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic       bridge_input_a_in,
    input  wire logic       bridge_input_b_in,
    input  wire logic       current_trip_in,
    input  wire logic       zero_current_in,
    input  wire logic       thermal_hot_in,
    input  wire logic       thermal_cool_in,
    input  wire logic       undervoltage_lockout_in,
    input  wire logic       overcurrent_in,
    input  wire logic       fault_retry_select_in,
    output logic [3:0]      gates_out,
    output logic            sync_rect_out,
    output logic            standby_out,
    output logic            fault_flag_low_out
);
    import bdpc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bdpc_phase_e        phase_r, phase_nxt;
    logic [CNT_W-1:0]   off_cnt_r, off_cnt_nxt;
    logic [CNT_W-1:0]   dead_cnt_r, dead_cnt_nxt;
    logic [CNT_W-1:0]   sby_cnt_r, sby_cnt_nxt;
    logic [CNT_W-1:0]   retry_cnt_r, retry_cnt_nxt;
    logic               hot_r, hot_nxt;
    logic               fault_r, fault_nxt;
    logic               standby_r, standby_nxt;
    logic               zero_r, zero_nxt;
    logic [3:0]         gates_r, gates_nxt;
    logic               sync_r, sync_nxt;
    logic               inhibit;
    logic               brake_cmd;
    logic               coast_cmd;
    logic [3:0]         drive_gates;
    logic [3:0]         fast_gates;

    assign brake_cmd = bridge_input_a_in & bridge_input_b_in;
    assign coast_cmd = ~bridge_input_a_in & ~bridge_input_b_in;
    // thermal, undervoltage, fault and standby all inhibit the bridge; the thermal and fault
    // latches' next values are used so the gates drop on the very edge that sets them
    assign inhibit = hot_nxt | undervoltage_lockout_in | fault_nxt | standby_r;

    // ------------------------------------------------------------
    // protection, standby and retry
    // ------------------------------------------------------------
    // thermal latch: trips at the hot mark, releases only at the cooler mark
    always_comb begin
        hot_nxt       = hot_r;
        fault_nxt     = fault_r;
        standby_nxt   = standby_r;
        sby_cnt_nxt   = sby_cnt_r;
        retry_cnt_nxt = retry_cnt_r;
        if (thermal_hot_in) begin
            hot_nxt = 1'b1;
        end else if (thermal_cool_in) begin
            hot_nxt = 1'b0;
        end
        if (coast_cmd) begin
            if (sby_cnt_r >= CNT_W'(STANDBY_LIMIT)) begin
                standby_nxt = 1'b1;
            end else begin
                sby_cnt_nxt = sby_cnt_r + 1'b1;
            end
        end else begin
            sby_cnt_nxt = '0;
            standby_nxt = 1'b0;
        end
        // leaving standby clears a latched fault; new overcurrent wins
        if (standby_r && !coast_cmd) begin
            fault_nxt = 1'b0;
        end
        if (fault_r && fault_retry_select_in) begin
            if (retry_cnt_r >= CNT_W'(RETRY_LIMIT - 1)) begin
                fault_nxt     = 1'b0;
                retry_cnt_nxt = '0;
            end else begin
                retry_cnt_nxt = retry_cnt_r + 1'b1;
            end
        end else begin
            retry_cnt_nxt = '0;
        end
        if (overcurrent_in) begin
            fault_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // off-time sequencer
    // ------------------------------------------------------------
    always_comb begin
        drive_gates = bridge_input_a_in ? GATES_FWD : GATES_REV;
        // fast decay reverses the diagonal so current falls into the supply
        fast_gates  = bridge_input_a_in ? GATES_REV : GATES_FWD;
    end

    always_comb begin
        phase_nxt    = phase_r;
        off_cnt_nxt  = off_cnt_r;
        dead_cnt_nxt = dead_cnt_r;
        zero_nxt     = zero_r;
        gates_nxt    = GATES_OFF;
        sync_nxt     = 1'b0;
        if (phase_r != BDPC_DRIVE) begin
            off_cnt_nxt = off_cnt_r + 1'b1;
        end
        if (zero_current_in) begin
            zero_nxt = 1'b1;
        end
        case (phase_r)
            BDPC_DRIVE: begin
            end
            BDPC_FAST: begin
                if (off_cnt_r >= CNT_W'(FAST_CYCLES - 1)) begin
                    phase_nxt    = BDPC_DEAD;
                    dead_cnt_nxt = '0;
                end
            end
            BDPC_DEAD: begin
                dead_cnt_nxt = dead_cnt_r + 1'b1;
                if (dead_cnt_r >= CNT_W'(DEAD_CYCLES - 1)) begin
                    phase_nxt = BDPC_SLOW;
                end
            end
            BDPC_SLOW: begin
                if (off_cnt_r >= CNT_W'(OFF_CYCLES - 1)) begin
                    phase_nxt = BDPC_DRIVE;
                end
            end
            default: begin
                phase_nxt = BDPC_DRIVE;
            end
        endcase
        // a trip restarts the whole off-time from zero, even mid-cycle
        if (current_trip_in && !brake_cmd && !coast_cmd) begin
            phase_nxt   = BDPC_FAST;
            off_cnt_nxt = '0;
            zero_nxt    = 1'b0;
        end
        // brake or coast abandons any decay phase before the gates are decoded,
        // so the short or the release takes effect on the very next edge
        if (brake_cmd || coast_cmd) begin
            phase_nxt = BDPC_DRIVE;
        end
        // gate decode from the next phase so the outputs line up with it
        case (phase_nxt)
            BDPC_DRIVE: begin
                if (brake_cmd) begin
                    gates_nxt = GATES_BRAKE;
                end else if (!coast_cmd) begin
                    gates_nxt = drive_gates;
                end
            end
            BDPC_FAST: begin
                gates_nxt = zero_nxt ? GATES_OFF : fast_gates;
                sync_nxt  = ~zero_nxt;
            end
            BDPC_DEAD: begin
                gates_nxt = GATES_OFF;
            end
            BDPC_SLOW: begin
                gates_nxt = zero_nxt ? GATES_OFF : GATES_BRAKE;
                sync_nxt  = ~zero_nxt;
            end
            default: begin
                gates_nxt = GATES_OFF;
            end
        endcase
        if (inhibit) begin
            phase_nxt = BDPC_DRIVE;
            gates_nxt = GATES_OFF;
            sync_nxt  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phase_r     <= BDPC_DRIVE;
            off_cnt_r   <= '0;
            dead_cnt_r  <= '0;
            sby_cnt_r   <= '0;
            retry_cnt_r <= '0;
            hot_r       <= 1'b0;
            fault_r     <= 1'b0;
            standby_r   <= 1'b0;
            zero_r      <= 1'b0;
            gates_r     <= GATES_OFF;
            sync_r      <= 1'b0;
        end else begin
            phase_r     <= phase_nxt;
            off_cnt_r   <= off_cnt_nxt;
            dead_cnt_r  <= dead_cnt_nxt;
            sby_cnt_r   <= sby_cnt_nxt;
            retry_cnt_r <= retry_cnt_nxt;
            hot_r       <= hot_nxt;
            fault_r     <= fault_nxt;
            standby_r   <= standby_nxt;
            zero_r      <= zero_nxt;
            gates_r     <= gates_nxt;
            sync_r      <= sync_nxt;
        end
    end

    assign gates_out          = gates_r;
    assign sync_rect_out      = sync_r;
    assign standby_out        = standby_r;
    assign fault_flag_low_out = ~fault_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_thermal_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
        hot_r |-> gates_r == GATES_OFF) else $error("gates on while hot");
    a_lockout_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
        undervoltage_lockout_in |=> gates_r == GATES_OFF) else $error("gates on in lockout");
    a_brake_short: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (brake_cmd && !inhibit) |=> gates_r == GATES_BRAKE) else $error("no brake");
    a_brake_release: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (!brake_cmd && phase_nxt == BDPC_DRIVE) |=> gates_r != GATES_BRAKE)
        else $error("brake held");
    a_trip_fast: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (current_trip_in && !brake_cmd && !coast_cmd && !inhibit) |=> phase_r == BDPC_FAST)
        else $error("trip missed");
    a_fast_len: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (phase_r == BDPC_FAST && off_cnt_r < CNT_W'(FAST_CYCLES - 1))
        |-> phase_nxt != BDPC_DEAD) else $error("fast decay short");
    a_dead_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
        phase_r == BDPC_DEAD |-> (gates_r == GATES_OFF && !sync_r))
        else $error("drivers on in dead time");
    a_zero_sync: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (zero_current_in && !current_trip_in) |=> !sync_r) else $error("sync after zero");
endmodule
`default_nettype wire

// ==== tb/bdpc_host_model.sv ====
// host controller model driving the two bridge inputs
`timescale 1ns/10ps
`default_nettype none
module bdpc_host_model (
    input  wire logic [1:0] cmd_in,
    output logic            bridge_input_a_out,
    output logic            bridge_input_b_out
);
    // the command only moves a fixed delay after an edge, so the pins follow it directly
    // brake (both high) is commanded from a drive state, and once in the middle of fast decay, by the bench sequence
    always_comb begin
        bridge_input_a_out = cmd_in[1];
        bridge_input_b_out = cmd_in[0];
    end
endmodule
`default_nettype wire

// ==== tb/bdpc_core_tb_top.sv ====
// self-checking bench for the bridge decay and protection controller
`timescale 1ns/10ps
`default_nettype none
module bdpc_core_tb_top;
    import bdpc_pkg::*;
    // ------------------------------------------------------------
    // stimulus and scoreboard state
    // ------------------------------------------------------------
    localparam int         STBY    = 20;
    localparam int         RETRY_N = 30;
    localparam logic [6:0] MG = 7'h78, MS = 7'h04, MB = 7'h02, MF = 7'h01;
    typedef struct {int cyc; logic [6:0] m; logic [6:0] v;} bdpc_exp_s;
    bdpc_exp_s   exp_q[$];
    logic        clock_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [1:0]  cmd = 2'b00;
    logic        trip = 1'b0, zc = 1'b0, hot = 1'b0, cool = 1'b1;
    logic        uv = 1'b0, oc = 1'b0, retry = 1'b0;
    logic        pin_a, pin_b, sync, stby, flt;
    logic [3:0]  gates;
    logic [6:0]  obs;
    logic [31:0] lfsr = 32'heee3;
    int          cyc = 0, n_mismatch = 0, samples_checked = 0;

    assign obs = {gates, sync, stby, flt};
    always #25 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;

    bdpc_host_model host (.cmd_in(cmd), .bridge_input_a_out(pin_a), .bridge_input_b_out(pin_b));
    bdpc_core #(.STANDBY_LIMIT(STBY), .RETRY_LIMIT(RETRY_N)) uut (
        .clock_in(clock_in), .resetn_in(resetn_in), .bridge_input_a_in(pin_a),
        .bridge_input_b_in(pin_b), .current_trip_in(trip), .zero_current_in(zc),
        .thermal_hot_in(hot), .thermal_cool_in(cool), .undervoltage_lockout_in(uv),
        .overcurrent_in(oc), .fault_retry_select_in(retry), .gates_out(gates),
        .sync_rect_out(sync), .standby_out(stby), .fault_flag_low_out(flt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [6:0] seen, input logic [6:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // notes must be pushed in rising cycle order, the monitor only looks at the head
    task automatic note(input int d, input logic [6:0] m, input logic [3:0] g,
                        input logic s, input logic sb, input logic f);
        exp_q.push_back('{cyc + d, m, {g, s, sb, f}});
    endtask
    // inputs always move 2 ns after an edge, the monitor reads outputs on the falling edge
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #2;
    endtask
    task automatic trip_pulse();
        trip = 1'b1;
        step(1);
        trip = 1'b0;
    endtask
    task automatic test_done();
        // an expectation that was never reached counts as a mismatch
        if (exp_q.size() > 0) begin
            n_mismatch++;
        end
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // monitor: compare each result against the oldest note once its cycle is reached
    always @(negedge clock_in) begin
        while (exp_q.size() > 0 && exp_q[0].cyc <= cyc) begin
            check(obs & exp_q[0].m, exp_q[0].v & exp_q[0].m);
            void'(exp_q.pop_front());
        end
    end

    // watchdog: far beyond the ~2000 cycles the sequence needs
    initial begin
        repeat (6000) @(posedge clock_in);
        n_mismatch++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        step(4);
        check(obs, {GATES_OFF, 3'b001});
        resetn_in = 1'b1;
        step(1);
        // reverse, forward and brake first, then random ones, never coast
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            cmd = (i < 3) ? 2'(i + 1) : ((lfsr[1:0] == 2'b00) ? 2'b11 : lfsr[1:0]);
            note(1, MG, (cmd == 2'b10) ? GATES_FWD : (cmd == 2'b01) ? GATES_REV : GATES_BRAKE,
                 1'b0, 1'b0, 1'b1);
            step(2);
        end
        cmd = 2'b10;
        step(2);
        note(1, MG | MS, GATES_REV, 1'b1, 1'b0, 1'b0);
        note(FAST_CYCLES, MG | MS, GATES_REV, 1'b1, 1'b0, 1'b0);
        note(FAST_CYCLES + 1, MG | MS, GATES_OFF, 1'b0, 1'b0, 1'b0);
        note(FAST_CYCLES + DEAD_CYCLES, MG | MS, GATES_OFF, 1'b0, 1'b0, 1'b0);
        note(FAST_CYCLES + DEAD_CYCLES + 1, MG | MS, GATES_BRAKE, 1'b1, 1'b0, 1'b0);
        note(OFF_CYCLES, MG | MS, GATES_BRAKE, 1'b1, 1'b0, 1'b0);
        note(OFF_CYCLES + 1, MG | MS, GATES_FWD, 1'b0, 1'b0, 1'b0);
        trip_pulse();
        step(OFF_CYCLES + 2);
        // a second trip inside slow decay restarts fast decay, then zero current
        trip_pulse();
        step(299);
        note(1, MG | MS, GATES_REV, 1'b1, 1'b0, 1'b0);
        note(10, MG | MS, GATES_REV, 1'b1, 1'b0, 1'b0);
        trip_pulse();
        step(10);
        zc = 1'b1;
        note(1, MG | MS, GATES_OFF, 1'b0, 1'b0, 1'b0);
        note(6, MG | MS, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(1);
        zc = 1'b0;
        step(OFF_CYCLES);
        // lockout in the middle of fast decay
        trip_pulse();
        step(5);
        uv = 1'b1;
        note(1, MG | MS, GATES_OFF, 1'b0, 1'b0, 1'b0);
        note(20, MG | MS, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(25);
        uv = 1'b0;
        note(1, MG, GATES_FWD, 1'b0, 1'b0, 1'b0);
        step(OFF_CYCLES);
        // thermal shutdown while braking, held in the hysteresis band
        cmd = 2'b11;
        step(2);
        hot = 1'b1;
        cool = 1'b0;
        note(1, MG, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(4);
        hot = 1'b0;
        note(3, MG, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(4);
        cool = 1'b1;
        note(1, MG, GATES_BRAKE, 1'b0, 1'b0, 1'b0);
        step(2);
        // overcurrent with retry, then latched
        cmd = 2'b10;
        step(2);
        retry = 1'b1;
        oc = 1'b1;
        note(1, MG | MF, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(1);
        oc = 1'b0;
        note(RETRY_N - 5, MG | MF, GATES_OFF, 1'b0, 1'b0, 1'b0);
        note(RETRY_N + 5, MG | MF, GATES_FWD, 1'b0, 1'b0, 1'b1);
        step(RETRY_N + 8);
        retry = 1'b0;
        oc = 1'b1;
        note(1, MG | MF, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(1);
        oc = 1'b0;
        note(RETRY_N + 10, MG | MF, GATES_OFF, 1'b0, 1'b0, 1'b0);
        step(RETRY_N + 12);
        // coast into standby, leaving it clears the latched fault
        cmd = 2'b00;
        note(STBY, MG | MB, GATES_OFF, 1'b0, 1'b0, 1'b0);
        note(STBY + 1, MG | MB, GATES_OFF, 1'b0, 1'b1, 1'b0);
        step(STBY + 5);
        cmd = 2'b10;
        note(5, MG | MB | MF, GATES_FWD, 1'b0, 1'b0, 1'b1);
        step(8);
        // brake in the middle of fast decay shorts at once, release drives again
        trip_pulse();
        step(3);
        cmd = 2'b11;
        note(1, MG | MS, GATES_BRAKE, 1'b0, 1'b0, 1'b1);
        step(2);
        cmd = 2'b10;
        note(1, MG | MS, GATES_FWD, 1'b0, 1'b0, 1'b1);
        step(2);
        test_done();
    end
endmodule
`default_nettype wire
